// ===== verilog/epd_divider.sv
// Encoder pulse divider with differential A/B/C outputs
`default_nettype none

// Contract
// - Divide encoder quadrature by setting; drive A, B, C as differential pairs.
// - Setting is output pulses per revolution; default 16384.
// - Accept 16..2048 on 13-bit, 16..16384 on 16-bit encoders.
// - 13-bit encoder with larger setting runs at 2048 pulses per revolution.
// - New setting takes effect only after power cycle; old one stays.
// - Division does not depend on electronic gear numerator or denominator.
module epd_divider
   import epd_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Configuration
   input wire logic [14:0] output_pulse_divider_setting,
   input wire logic encoder_is_13bit,
   input wire logic [15:0] gear_numerator_setting,
   input wire logic [15:0] gear_denominator_setting,
   // Motor position encoder pins
   input wire logic [2:0] motor_position_encoder,
   // Divided outputs
   output epd_diff_type divided_out,
   output logic divided_phase_a_out,
   output logic divided_phase_b_out,
   output logic index_phase_c_out,
   output logic [14:0] active_divider
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // Three flops; a change counts once stages two and three agree
   function automatic logic settled(input logic mid, input logic last,
                                    input logic held);
      settled = (mid == last) ? last : held;
   endfunction

   logic [2:0] s1_q;
   logic [2:0] s2_q;
   logic [2:0] s3_q;
   epd_phase_type in_q;
   epd_phase_type in_d;

   // Flop chain
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
      end else begin
         s1_q <= motor_position_encoder;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Agreement filter per channel
   always_comb begin
      in_d.a = settled(s2_q[2], s3_q[2], in_q.a);
      in_d.b = settled(s2_q[1], s3_q[1], in_q.b);
      in_d.c = settled(s2_q[0], s3_q[0], in_q.c);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         in_q <= '0;
      else
         in_q <= in_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Setting latch after reset release
   function automatic logic [14:0] native_ppr(input logic r13);
      native_ppr = r13 ? EPD_RES13_PPR : EPD_RES16_PPR;
   endfunction

   function automatic logic [14:0] clamp_setting(input logic [14:0] s,
                                                  input logic r13);
      logic [14:0] lim;
      lim = native_ppr(r13);
      if (s < EPD_DIV_MIN)
         clamp_setting = EPD_DIV_MIN;
      else if (s > lim)
         clamp_setting = lim;
      else
         clamp_setting = s;
   endfunction

   logic latched_q;
   logic [14:0] div_q;
   logic [14:0] enc_ppr_q;

   // One-shot capture after reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         latched_q <= 1'b0;
      else
         latched_q <= 1'b1;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         div_q <= EPD_DIV_RESET;
      else if (!latched_q)
         div_q <= clamp_setting(output_pulse_divider_setting,
                                encoder_is_13bit);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         enc_ppr_q <= EPD_RES16_PPR;
      else if (!latched_q)
         enc_ppr_q <= native_ppr(encoder_is_13bit);
   end

   assign active_divider = div_q;

   ////////////////////////////////////////////////////////////////////////
   // Quadrature decode of the input
   logic prev_a_q;
   logic prev_b_q;
   logic prev_c_q;
   logic step;
   logic dir_up;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_a_q <= 1'b0;
         prev_b_q <= 1'b0;
         prev_c_q <= 1'b0;
      end else begin
         prev_a_q <= in_q.a;
         prev_b_q <= in_q.b;
         prev_c_q <= in_q.c;
      end
   end
   assign step = (in_q.a ^ prev_a_q) ^ (in_q.b ^ prev_b_q);
   assign dir_up = in_q.a ^ prev_b_q;

   ////////////////////////////////////////////////////////////////////////
   // Rate accumulator, gear settings unused
   // Edge accumulator: out edges = in edges * div / enc_ppr
   logic [15:0] acc_q;
   logic [1:0] out_state_q;
   logic [15:0] acc_sum;
   logic [15:0] acc_dif;
   logic emit;
   assign acc_sum = acc_q + {1'b0, div_q};
   assign acc_dif = acc_q - {1'b0, div_q};
   always_comb begin
      emit = 1'b0;
      if (step) begin
         if (dir_up)
            emit = acc_sum >= {1'b0, enc_ppr_q};
         else
            emit = acc_q < {1'b0, div_q};
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= 16'h0000;
      end else if (step) begin
         if (dir_up)
            acc_q <= emit ? acc_sum - {1'b0, enc_ppr_q} : acc_sum;
         else
            acc_q <= emit ? acc_dif + {1'b0, enc_ppr_q} : acc_dif;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Gray sequence of the output
   logic [1:0] out_state_d;

   always_comb begin
      out_state_d = out_state_q;
      if (emit && dir_up)
         out_state_d = out_state_q + 2'h1;
      else if (emit)
         out_state_d = out_state_q - 2'h1;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         out_state_q <= 2'h0;
      else
         out_state_q <= out_state_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Output drivers
   // Single-ended A and B; A leads while counting up
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         divided_phase_a_out <= 1'b0;
         divided_phase_b_out <= 1'b0;
      end else begin
         divided_phase_a_out <= out_state_q[1] ^ out_state_q[0];
         divided_phase_b_out <= out_state_q[1];
      end
   end

   // Index passes through, filtered one cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         index_phase_c_out <= 1'b0;
      else
         index_phase_c_out <= in_q.c & prev_c_q;
   end

   // Differential pairs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         divided_out <= 6'h15;
      end else begin
         divided_out.a_p <= divided_phase_a_out;
         divided_out.a_n <= ~divided_phase_a_out;
         divided_out.b_p <= divided_phase_b_out;
         divided_out.b_n <= ~divided_phase_b_out;
         divided_out.c_p <= index_phase_c_out;
         divided_out.c_n <= ~index_phase_c_out;
      end
   end

endmodule
`default_nettype wire

// ===== pkg/epd_pkg.sv
// Constants and types for the encoder pulse divider output
`default_nettype none
package epd_pkg;
   localparam logic [14:0] EPD_DIV_MIN = 15'h0010;
   localparam logic [14:0] EPD_DIV_DEFAULT = 15'h4000;
   localparam logic [14:0] EPD_RES13_PPR = 15'h0800;
   localparam logic [14:0] EPD_RES16_PPR = 15'h4000;
   localparam logic [14:0] EPD_DIV_RESET = 15'h4000;

   typedef struct packed {
      logic a;
      logic b;
      logic c;
   } epd_phase_type;

   typedef struct packed {
      logic a_p;
      logic a_n;
      logic b_p;
      logic b_n;
      logic c_p;
      logic c_n;
   } epd_diff_type;
endpackage
`default_nettype wire

// ===== verif/epd_chk_assertions.sv
// Checker for the encoder pulse divider ports
`default_nettype none
module epd_chk
   import epd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [14:0] output_pulse_divider_setting,
   input wire logic encoder_is_13bit,
   input wire logic [2:0] motor_position_encoder,
   input wire epd_diff_type divided_out,
   input wire logic divided_phase_a_out,
   input wire logic divided_phase_b_out,
   input wire logic index_phase_c_out,
   input wire logic [14:0] active_divider
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic go_q;
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         go_q <= 1'b0;
      else
         go_q <= 1'b1;
   pair_a_a: assert property (
      divided_out.a_p == $past(divided_phase_a_out) &&
      divided_out.a_n != divided_out.a_p) else $error("a pair");
   pair_bc_a: assert property (
      divided_out.b_p == $past(divided_phase_b_out) &&
      divided_out.c_n == !$past(index_phase_c_out)) else $error("bc pair");
   quad_a: assert property (
      !($changed(divided_phase_a_out) && $changed(divided_phase_b_out)))
      else $error("a and b moved together");
   range_a: assert property (
      active_divider >= EPD_DIV_MIN && active_divider <= EPD_RES16_PPR)
      else $error("divider out of range");
   hold_a: assert property (
      go_q && $past(go_q) |-> $stable(active_divider))
      else $error("divider changed");
   cap13_a: assert property (
      $rose(go_q) && $past(encoder_is_13bit) &&
      $past(output_pulse_divider_setting) > EPD_RES13_PPR
      |-> active_divider == EPD_RES13_PPR) else $error("no cap");
   quiet_a: assert property (
      $stable(motor_position_encoder) [*8] |=>
      $stable({divided_phase_a_out, divided_phase_b_out}))
      else $error("output moved alone");
endmodule
bind epd_divider epd_chk chk (.*);
`default_nettype wire

// ===== verif/epd_host.sv
// Host position counter fed by the divided lines
`default_nettype none
module epd_host
   import epd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire epd_diff_type line,
   output logic signed [15:0] pos,
   output logic [7:0] idx
);
   logic a_q, b_q, c_q;
   wire logic a = line.a_p & ~line.a_n;
   wire logic b = line.b_p & ~line.b_n;
   wire logic c = line.c_p & ~line.c_n;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         {a_q, b_q, c_q} <= 3'h0;
         pos <= 16'sh0000;
         idx <= 8'h00;
      end else begin
         {a_q, b_q, c_q} <= {a, b, c};
         if ((a ^ a_q) | (b ^ b_q))
            pos <= (a ^ b_q) ? pos + 16'sh0001 : pos - 16'sh0001;
         if (c & ~c_q)
            idx <= idx + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Testbench for the encoder pulse divider
`default_nettype none
`define CHK(g, e) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      err_total++; \
      $display("CHECK FAILED %0t %h %h", $time, g, e); \
   end \
end
module testbench
   import epd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0, rst_n = 0, r13 = 0, pa, pb, pc;
   logic [14:0] set = 15'h4000, act;
   logic [15:0] gn = 16'h0004, gd = 16'h0001;
   logic [2:0] enc = 3'h0;
   logic [1:0] ph = 2'h0;
   epd_diff_type dl;
   logic signed [15:0] pos;
   logic [7:0] idx;
   int err_total = 0, checks_done = 0;
   always #4 sys_clk = ~sys_clk;
   epd_divider dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .output_pulse_divider_setting(set), .encoder_is_13bit(r13),
      .gear_numerator_setting(gn), .gear_denominator_setting(gd),
      .motor_position_encoder(enc), .divided_out(dl),
      .divided_phase_a_out(pa), .divided_phase_b_out(pb),
      .index_phase_c_out(pc), .active_divider(act));
   epd_host host (.sys_clk(sys_clk), .rst_n(rst_n), .line(dl),
      .pos(pos), .idx(idx));
   task automatic cyc(int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic t_cfg(logic [14:0] s, logic m, logic [14:0] e);
      rst_n = 0;
      set = s;
      r13 = m;
      cyc(10);
      rst_n = 1;
      cyc(3);
      `CHK(act, e)
      set = ~s;
      cyc(3);
      `CHK(act, e)
   endtask
   task automatic t_run(int n, logic fwd, int e, int ei);
      for (int i = 0; i < n; i++) begin
         ph = fwd ? ph + 2'h1 : ph - 2'h1;
         enc = {ph[1] ^ ph[0], ph[1], i == 0};
         cyc(5);
      end
      enc[0] = 1'b0;
      cyc(12);
      `CHK(pos, 16'(e))
      `CHK(idx, 8'(ei))
   endtask
   task automatic conclude();
      if (err_total == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      t_cfg(15'h0005, 1'b1, 15'h0010);
      t_cfg(15'h0fa0, 1'b1, 15'h0800);
      t_cfg(15'h4000, 1'b0, 15'h4000);
      t_cfg(15'h0010, 1'b1, 15'h0010);
      t_run(1024, 1'b1, 8, 1);
      gn = 16'h6000;
      gd = 16'h0e10;
      t_run(1024, 1'b0, 0, 2);
      conclude();
   end
endmodule
`default_nettype wire
